// [design/cgr_pkg.sv]
package cgr_pkg;
   // byte offsets of the bank
   localparam logic [7:0] CGR_OFS_IDENT   = 8'h06;
   localparam logic [7:0] CGR_OFS_BCOUNT  = 8'h07;
   localparam logic [7:0] CGR_OFS_RSVD8   = 8'h08;
   localparam logic [7:0] CGR_OFS_RSVD9   = 8'h09;
   localparam logic [7:0] CGR_OFS_PROG    = 8'h0A;
   localparam logic [7:0] CGR_OFS_STOP    = 8'h0B;
   localparam logic [7:0] CGR_OFS_IMP_LO  = 8'h0C;
   localparam logic [7:0] CGR_OFS_IMP_HI  = 8'h0D;
   localparam logic [7:0] CGR_OFS_BIAS    = 8'h0E;
   // field positions
   localparam int CGR_BIT_MN_EN    = 7;
   localparam int CGR_BIT_PD_KEEP  = 6;
   localparam int CGR_LSB_IMP_EVEN = 2;
   localparam int CGR_LSB_IMP_ODD0 = 6;
   localparam int CGR_LSB_IMP_ODD1 = 4;
   localparam int CGR_LSB_BIAS0    = 2;
   localparam int CGR_LSB_BIAS1    = 6;
   // writable-bit masks
   localparam logic [7:0] CGR_MSK_BCOUNT = 8'h1F;
   localparam logic [7:0] CGR_MSK_PROG   = 8'hC0;
   localparam logic [7:0] CGR_MSK_STOP   = 8'h03;
   localparam logic [7:0] CGR_MSK_IMP_LO = 8'hCC;
   localparam logic [7:0] CGR_MSK_IMP_HI = 8'h3C;
   localparam logic [7:0] CGR_MSK_BIAS   = 8'hCC;
   // reset values
   localparam logic [7:0] CGR_RST_BCOUNT = 8'h08;
   localparam logic [7:0] CGR_RST_PROG   = 8'h40;
   localparam logic [7:0] CGR_RST_STOP   = 8'h00;
   localparam logic [7:0] CGR_RST_BIAS   = 8'h44;
   localparam logic [1:0] CGR_IMP_100    = 2'h2;
   // stop-state encodings: true/complement levels
   typedef enum logic [1:0] {
      CGR_STOP_LOW_LOW  = 2'h0,
      CGR_STOP_HIZ_HIZ  = 2'h1,
      CGR_STOP_HIGH_LOW = 2'h2,
      CGR_STOP_LOW_HIGH = 2'h3
   } cgr_stop_t;
endpackage : cgr_pkg

// [design/cgr_stop_drive.sv]
`timescale 1ns/1ns
`default_nettype none
// one differential output's disable override
module cgr_stop_drive
   import cgr_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       out_en_i,
   input  wire logic [1:0] stop_sel_i,
   output logic            force_o,
   output logic            true_lvl_o,
   output logic            comp_lvl_o,
   output logic            true_oe_n_o,
   output logic            comp_oe_n_o
);
   logic [3:0] drv_nxt;
   logic [3:0] drv_r;

   // decode stop code into level and enable (enable low = driven)
   always_comb
   begin
      case (cgr_stop_t'(stop_sel_i))
         CGR_STOP_HIZ_HIZ:  drv_nxt = 4'h3;
         CGR_STOP_HIGH_LOW: drv_nxt = 4'h8;
         CGR_STOP_LOW_HIGH: drv_nxt = 4'h4;
         default:           drv_nxt = 4'h0;
      endcase
   end

   // registered outputs, low/low driven after reset
   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         drv_r   <= 4'h0;
         force_o <= 1'b0;
      end
      else
      begin
         drv_r   <= drv_nxt;
         force_o <= ~out_en_i;
      end
   end

   assign true_lvl_o  = drv_r[3];
   assign comp_lvl_o  = drv_r[2];
   assign true_oe_n_o = drv_r[1];
   assign comp_oe_n_o = drv_r[0];
endmodule : cgr_stop_drive
`default_nettype wire

// [design/cgr_regs.sv]
`timescale 1ns/1ns
`default_nettype none
// How it works
// - offset 10 bit 7 enables multiplier/divider programming, resetting to 0.
// - offset 10 bit 6 set keeps configuration through power-down, clear restores defaults of all bytes but 10; resets 1.
// - offset 11 bits 1:0 pick disabled levels 00 low/low, 01 hi-z, 10 high/low, 11 low/high.
// - each output has a two-bit impedance code 33/85/100 ohm, outputs 0-1 in byte 12, 2-3 in 13.
// - offset 14 holds bias selects for enable pins 0 (3:2) and 1 (7:6), each resetting to 01.
// - offsets 8 and 9 are reserved, read zero and ignore writes.
// - a cleared per-output enable forces that output into the selected stop state.
module cgr_regs
   import cgr_pkg::*;
#(
   parameter int         NUM_OUT      = 4,
   parameter logic [1:0] PART_CLASS   = 2'h2, // arbitrary value
   parameter logic [5:0] PART_IDENT   = 6'h2A, // arbitrary value
   parameter logic [7:0] IMP_DEFAULT  = 8'hAA  // 100 ohm for every output
)
(
   input  wire logic               ref_clk_i,
   input  wire logic               resetn_i,
   input  wire logic [7:0]         reg_addr_i,
   input  wire logic               reg_wr_i,
   input  wire logic [7:0]         reg_wdata_i,
   output logic      [7:0]         reg_rdata_o,
   input  wire logic               powerdown_i,
   input  wire logic [NUM_OUT-1:0] out_en_i,
   output logic      [4:0]         block_read_len_o,
   output logic                    divider_prog_en_o,
   output logic                    powerdown_keep_config_o,
   output logic      [1:0]         stop_level_sel_o,
   output logic      [2*NUM_OUT-1:0] out_impedance_sel_o,
   output logic      [1:0]         enable_pin0_bias_sel_o,
   output logic      [1:0]         enable_pin1_bias_sel_o,
   output logic      [NUM_OUT-1:0] out_forced_o,
   output logic      [NUM_OUT-1:0] true_lvl_o,
   output logic      [NUM_OUT-1:0] comp_lvl_o,
   output logic      [NUM_OUT-1:0] true_oe_n_o,
   output logic      [NUM_OUT-1:0] comp_oe_n_o
);
   logic [7:0] bcount_r;
   logic [7:0] prog_r;
   logic [7:0] stop_r;
   logic [7:0] imp_lo_r;
   logic [7:0] imp_hi_r;
   logic [7:0] bias_r;
   logic [7:0] rdata_nxt;
   logic [7:0] rdata_r;
   logic       pd_s1_r;
   logic       pd_s2_r;

   // merge write data into the writable bits only
   function automatic logic [7:0] wr_merge(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] msk);
      wr_merge = (old_v & ~msk) | (new_v & msk);
   endfunction : wr_merge

   // true when the byte index selects the given offset
   function automatic logic addr_hit(input logic [7:0] idx,
                                     input logic [7:0] ofs);
      addr_hit = (idx == ofs);
   endfunction : addr_hit

   // address decode
   wire wr_bcount = reg_wr_i && addr_hit(reg_addr_i, CGR_OFS_BCOUNT);
   wire wr_prog   = reg_wr_i && addr_hit(reg_addr_i, CGR_OFS_PROG);
   wire wr_stop   = reg_wr_i && addr_hit(reg_addr_i, CGR_OFS_STOP);
   wire wr_imp_lo = reg_wr_i && addr_hit(reg_addr_i, CGR_OFS_IMP_LO);
   wire wr_imp_hi = reg_wr_i && addr_hit(reg_addr_i, CGR_OFS_IMP_HI);
   wire wr_bias   = reg_wr_i && addr_hit(reg_addr_i, CGR_OFS_BIAS);

   // restore at reset, or on synchronised power-down only when keep flag is clear
   wire pd_restore = pd_s2_r && !prog_r[CGR_BIT_PD_KEEP];
   wire restore    = !resetn_i || pd_restore;
   wire [7:0] imp_lo_def = {IMP_DEFAULT[3:2], 2'h0, IMP_DEFAULT[1:0], 2'h0};
   wire [7:0] imp_hi_def = {2'h0, IMP_DEFAULT[7:6], IMP_DEFAULT[5:4], 2'h0};

   // stop code shared by every output's override
   wire [1:0] stop_code = stop_r[1:0];

   // two-flop synchroniser for the power-down pin
   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         pd_s1_r <= 1'b0;
         pd_s2_r <= 1'b0;
      end
      else
      begin
         pd_s1_r <= powerdown_i;
         pd_s2_r <= pd_s1_r;
      end
   end

   // keep flag and programming enable: reset only, not cleared by power-down
   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
         prog_r <= CGR_RST_PROG;
      else if (wr_prog)
         prog_r <= wr_merge(prog_r, reg_wdata_i, CGR_MSK_PROG);
   end

   // block-read count, back to eight at reset or lossy power-down
   always_ff @(posedge ref_clk_i)
   begin
      if (restore)
         bcount_r <= CGR_RST_BCOUNT;
      else if (wr_bcount)
         bcount_r <= wr_merge(bcount_r, reg_wdata_i, CGR_MSK_BCOUNT);
   end

   // stop-state code, back to low/low on restore
   always_ff @(posedge ref_clk_i)
   begin
      if (restore)
         stop_r <= CGR_RST_STOP;
      else if (wr_stop)
         stop_r <= wr_merge(stop_r, reg_wdata_i, CGR_MSK_STOP);
   end

   // impedance codes of outputs 0 and 1
   always_ff @(posedge ref_clk_i)
   begin
      if (restore)
         imp_lo_r <= imp_lo_def;
      else if (wr_imp_lo)
         imp_lo_r <= wr_merge(imp_lo_r, reg_wdata_i, CGR_MSK_IMP_LO);
   end

   // impedance codes of outputs 2 and 3
   always_ff @(posedge ref_clk_i)
   begin
      if (restore)
         imp_hi_r <= imp_hi_def;
      else if (wr_imp_hi)
         imp_hi_r <= wr_merge(imp_hi_r, reg_wdata_i, CGR_MSK_IMP_HI);
   end

   // enable-pin bias selects, back to pull-down on restore
   always_ff @(posedge ref_clk_i)
   begin
      if (restore)
         bias_r <= CGR_RST_BIAS;
      else if (wr_bias)
         bias_r <= wr_merge(bias_r, reg_wdata_i, CGR_MSK_BIAS);
   end

   // read mux; reserved offsets and unmapped bytes read zero
   always_comb
   begin
      if (reg_addr_i == CGR_OFS_IDENT)
         rdata_nxt = {PART_CLASS, PART_IDENT};
      else if (reg_addr_i == CGR_OFS_BCOUNT)
         rdata_nxt = bcount_r;
      else if (reg_addr_i == CGR_OFS_RSVD8 || reg_addr_i == CGR_OFS_RSVD9)
         rdata_nxt = 8'h00;
      else if (reg_addr_i == CGR_OFS_PROG)
         rdata_nxt = prog_r;
      else if (reg_addr_i == CGR_OFS_STOP)
         rdata_nxt = stop_r;
      else if (reg_addr_i == CGR_OFS_IMP_LO)
         rdata_nxt = imp_lo_r;
      else if (reg_addr_i == CGR_OFS_IMP_HI)
         rdata_nxt = imp_hi_r;
      else if (reg_addr_i == CGR_OFS_BIAS)
         rdata_nxt = bias_r;
      else
         rdata_nxt = 8'h00;
   end

   // read data registered one cycle behind the index
   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end

   // field outputs
   assign reg_rdata_o             = rdata_r;
   assign block_read_len_o        = bcount_r[4:0];
   assign divider_prog_en_o       = prog_r[CGR_BIT_MN_EN];
   assign powerdown_keep_config_o = prog_r[CGR_BIT_PD_KEEP];
   assign stop_level_sel_o        = stop_code;
   assign enable_pin0_bias_sel_o  = bias_r[CGR_LSB_BIAS0 +: 2];
   assign enable_pin1_bias_sel_o  = bias_r[CGR_LSB_BIAS1 +: 2];
   assign out_impedance_sel_o[1:0] = imp_lo_r[CGR_LSB_IMP_EVEN +: 2];
   assign out_impedance_sel_o[3:2] = imp_lo_r[CGR_LSB_IMP_ODD0 +: 2];
   assign out_impedance_sel_o[5:4] = imp_hi_r[CGR_LSB_IMP_EVEN +: 2];
   assign out_impedance_sel_o[7:6] = imp_hi_r[CGR_LSB_IMP_ODD1 +: 2];

   // per-output disable override
   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g = g + 1)
      begin : g_out
         cgr_stop_drive u_drv (
            .ref_clk_i   (ref_clk_i),
            .resetn_i    (resetn_i),
            .out_en_i    (out_en_i[g]),
            .stop_sel_i  (stop_code),
            .force_o     (out_forced_o[g]),
            .true_lvl_o  (true_lvl_o[g]),
            .comp_lvl_o  (comp_lvl_o[g]),
            .true_oe_n_o (true_oe_n_o[g]),
            .comp_oe_n_o (comp_oe_n_o[g])
         );
      end
   endgenerate
endmodule : cgr_regs
`default_nettype wire

// [testbench/cgr_regs_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module cgr_regs_checker
   import cgr_pkg::*;
#(
   parameter logic [1:0] PART_CLASS = 2'h2,
   parameter logic [5:0] PART_IDENT = 6'h2A
)
(
   input wire logic       ref_clk_i,
   input wire logic       resetn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       powerdown_i,
   input wire logic [3:0] out_en_i,
   input wire logic [4:0] block_read_len_o,
   input wire logic       divider_prog_en_o,
   input wire logic       powerdown_keep_config_o,
   input wire logic [1:0] stop_level_sel_o,
   input wire logic [7:0] out_impedance_sel_o,
   input wire logic [1:0] enable_pin0_bias_sel_o,
   input wire logic [3:0] out_forced_o,
   input wire logic [3:0] true_oe_n_o,
   input wire logic [3:0] comp_oe_n_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // a taken byte lands in its field one cycle later
   a_count_write: assert property (
      reg_wr_i && reg_addr_i == CGR_OFS_BCOUNT && powerdown_keep_config_o
      |=> block_read_len_o == $past(reg_wdata_i[4:0])) else $error("count write lost");
   a_prog_write: assert property (
      reg_wr_i && reg_addr_i == CGR_OFS_PROG
      |=> {divider_prog_en_o, powerdown_keep_config_o} == $past(reg_wdata_i[7:6]))
      else $error("prog write lost");
   a_imp_write: assert property (
      reg_wr_i && reg_addr_i == CGR_OFS_IMP_LO && powerdown_keep_config_o
      |=> out_impedance_sel_o[3:0] == {$past(reg_wdata_i[7:6]), $past(reg_wdata_i[3:2])})
      else $error("impedance write lost");
   // read side: fixed and reserved bytes
   a_ident_read: assert property (
      $past(resetn_i) && $past(reg_addr_i) == CGR_OFS_IDENT
      |-> reg_rdata_o == {PART_CLASS, PART_IDENT}) else $error("ident byte wrong");
   a_rsvd_read: assert property (
      $past(resetn_i) && $past(reg_addr_i[7:1]) == 7'h04 |-> reg_rdata_o == 8'h00)
      else $error("reserved byte not zero");
   // disable override and stop levels
   a_force_follow: assert property (
      $past(resetn_i) |-> out_forced_o == ~$past(out_en_i)) else $error("force late");
   a_hiz_stop: assert property (
      (out_forced_o[0] && stop_level_sel_o == 2'h1) [*2] |-> true_oe_n_o[0] && comp_oe_n_o[0])
      else $error("hiz stop not driven");
   // power-down restore or keep
   a_pd_restore: assert property (
      (powerdown_i && !powerdown_keep_config_o && !reg_wr_i) [*4]
      |-> block_read_len_o == 5'h08 && stop_level_sel_o == 2'h0
      && enable_pin0_bias_sel_o == 2'h1) else $error("restore missing");
   a_keep_hold: assert property (
      (powerdown_i && powerdown_keep_config_o && !reg_wr_i) [*2] |-> $stable(block_read_len_o))
      else $error("config lost in keep mode");
   c_restore: cover property ((powerdown_i && !powerdown_keep_config_o) [*4]);
   c_low_high: cover property (out_forced_o[0] && stop_level_sel_o == 2'h3);
   c_count: cover property (reg_wr_i && reg_addr_i == CGR_OFS_BCOUNT);
endmodule : cgr_regs_checker
bind cgr_regs cgr_regs_checker #(.PART_CLASS(PART_CLASS), .PART_IDENT(PART_IDENT)) u_chk (.*);
`default_nettype wire

// [testbench/cgr_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// host side: single-byte writes and indexed reads
module cgr_host_model (
   input  wire logic       ref_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic      [7:0] reg_wdata_o
);
   initial reg_addr_o = 8'h00;
   initial reg_wr_o = 1'b0;
   initial reg_wdata_o = 8'h00;
   // strobe for one edge, then scramble the data lines
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_o  <= a;
      reg_wr_o    <= 1'b1;
      reg_wdata_o <= d;
      @(posedge ref_clk_i);
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= ~d;
   endtask : wr
   // data is taken one cycle after the index, sampled at the following falling edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_o <= a;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      d = reg_rdata_i;
   endtask : rd
endmodule : cgr_host_model
`default_nettype wire

// [testbench/clock_gen_config_regs_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) if ((a) !== (e)) begin $display("[ERR] %s exp %h got %h", nm, e, a); err_total++; end n_tests++;
module clock_gen_config_regs_test;
   localparam logic [1:0] PC = 2'h1; // arbitrary value
   localparam logic [5:0] PI = 6'h15; // arbitrary value
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic powerdown_i = 1'b0;
   logic [3:0] out_en_i = 4'hF;
   logic [7:0] addr, wdata, rdata, d;
   logic wr;
   logic [4:0] blen;
   logic [7:0] imp;
   logic [1:0] stop, b0, b1;
   logic dpe, keep;
   logic [3:0] frc, tl, cl, toe, coe;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [7:0] ofs [10] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h20};
   logic [7:0] rst_v [10] = '{{PC, PI}, 8'h08, 8'h00, 8'h00, 8'h40,
                              8'h00, 8'h88, 8'h28, 8'h44, 8'h00};
   logic [7:0] ff_v [10] = '{{PC, PI}, 8'h1F, 8'h00, 8'h00, 8'hC0,
                             8'h03, 8'hCC, 8'h3C, 8'hCC, 8'h00};
   always #4 ref_clk_i = ~ref_clk_i;
   cgr_host_model u_host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wr_o(wr), .reg_wdata_o(wdata));
   cgr_regs #(.PART_CLASS(PC), .PART_IDENT(PI)) dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .powerdown_i(powerdown_i), .out_en_i(out_en_i), .block_read_len_o(blen),
      .divider_prog_en_o(dpe), .powerdown_keep_config_o(keep), .stop_level_sel_o(stop),
      .out_impedance_sel_o(imp), .enable_pin0_bias_sel_o(b0), .enable_pin1_bias_sel_o(b1),
      .out_forced_o(frc), .true_lvl_o(tl), .comp_lvl_o(cl), .true_oe_n_o(toe),
      .comp_oe_n_o(coe));
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   // hang guard
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (3) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      // reset values, reserved and unmapped bytes
      for (int i = 0; i < 10; i++)
      begin
         u_host.rd(ofs[i], d);
         `CHK("reset byte", rst_v[i], d)
      end
      // all ones everywhere: read-only and reserved bits stay put
      for (int i = 0; i < 10; i++)
         u_host.wr(ofs[i], 8'hFF);
      for (int i = 0; i < 10; i++)
      begin
         u_host.rd(ofs[i], d);
         `CHK("ff byte", ff_v[i], d)
      end
      `CHK("fields", {5'h1F, 2'h3, 8'hFF, 4'hF}, {blen, dpe, keep, imp, b0, b1})
      `CHK("no force", 4'h0, frc)
      // codes that differ within each byte show the field order
      u_host.wr(8'h0C, 8'h84);
      u_host.wr(8'h0D, 8'h34);
      @(negedge ref_clk_i);
      `CHK("imp order", 8'hD9, imp)
      // every stop code on a disabled output
      @(posedge ref_clk_i);
      out_en_i <= 4'hE;
      for (int i = 0; i < 4; i++)
      begin
         u_host.wr(8'h0B, 8'(i));
         repeat (3) @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         `CHK("forced", 4'h1, frc)
         `CHK("stop code", 2'(i), stop)
         `CHK("stop oe", {2{i == 1}}, {toe[0], coe[0]})
         if (i != 1)
         begin
            `CHK("stop lvl", {i == 2, i == 3}, {tl[0], cl[0]})
         end
      end
      @(posedge ref_clk_i);
      out_en_i <= 4'hF;
      // power-down with restore, byte 10 itself untouched
      u_host.wr(8'h0A, 8'h00);
      u_host.wr(8'h07, 8'h03);
      powerdown_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      u_host.rd(8'h07, d);
      `CHK("restored count", 8'h08, d)
      u_host.rd(8'h0E, d);
      `CHK("restored bias", 8'h44, d)
      u_host.rd(8'h0A, d);
      `CHK("prog byte", 8'h00, d)
      `CHK("restored stop", 2'h0, stop)
      // power-down with keep
      @(posedge ref_clk_i);
      powerdown_i <= 1'b0;
      u_host.wr(8'h0A, 8'h40);
      u_host.wr(8'h07, 8'h05);
      powerdown_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      u_host.rd(8'h07, d);
      `CHK("kept count", 8'h05, d)
      print_verdict();
   end
endmodule : clock_gen_config_regs_test
`default_nettype wire
